// ### design/alp_operand_prep.sv
// Design decisions made here: register access over AXI4-Lite and the register offsets.

`default_nettype none

module alp_operand_prep (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      adder_gen,
    output logic [31:0]      adder_gen_n,
    output logic [31:0]      adder_prop,
    output logic [31:0]      adder_prop_n,
    output logic [31:0]      logic_result,
    output logic [3:0]       low_nibble_propagate,
    output logic [3:0]       low_nibble_generate,
    output logic [3:0]       byte_group_propagate,
    output logic [3:0]       byte_group_generate,
    output logic [7:0]       thread_onehot,
    output logic [7:0]       thread_onehot_n,
    output logic [3:0]       reg_field,
    output logic [3:0]       reg_field_n,
    output logic [31:0]      unload_word,
    output logic [31:0]      unload_word_n,
    output logic [31:0]      rail_word,
    output logic [31:0]      rail_word_n
);

    alp_pkg::alp_state_t q;
    alp_pkg::alp_state_t d;

    // Register address decode used by both the write and read paths.
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr[1:0] == 2'b00) && (addr <= alp_pkg::OFF_RAIL);
    endfunction

    // Byte-lane merge of a write into a stored word.
    function automatic logic [31:0] merge_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old;
        for (int k = 0; k < 4; k++) begin
            if (strb[k]) begin
                res[8*k +: 8] = wd[8*k +: 8];
            end
        end
        merge_strb = res;
    endfunction

    // Read-back multiplexer of all registers.
    function automatic logic [31:0] read_mux(input alp_pkg::alp_state_t s,
                                             input logic [7:0] addr);
        logic [31:0] v;
        v = alp_pkg::WORD_ZERO;
        case (addr)
            alp_pkg::OFF_CTRL:    v = s.ctrl;
            alp_pkg::OFF_ALIGNED: v = s.aligned;
            alp_pkg::OFF_MAINBUS: v = s.bus_n;
            alp_pkg::OFF_RFWORD:  v = s.rf_word;
            alp_pkg::OFF_CONST:   v = s.const_w;
            alp_pkg::OFF_GEN:     v = s.gen;
            alp_pkg::OFF_PROP:    v = s.prop;
            alp_pkg::OFF_LOGIC:   v = s.logic_w;
            alp_pkg::OFF_GROUP:   v = {16'h0000, s.byte_g, s.byte_p, s.nib_g, s.nib_p};
            alp_pkg::OFF_SELECT:  v = {20'h0_0000, s.rfield, s.onehot};
            alp_pkg::OFF_UNLOAD:  v = s.unload;
            alp_pkg::OFF_RAIL:    v = s.rail;
            default:              v = alp_pkg::WORD_ZERO;
        endcase
        read_mux = v;
    endfunction

    // Control fields decoded from the control register.
    logic       op_add;
    logic       op_sub;
    logic       op_inc;
    logic       op_dec;
    logic       half_arith;
    logic [1:0] width_sel;
    logic [2:0] thread_select_code;
    logic [3:0] current_instr_field;

    assign op_add              = q.ctrl[alp_pkg::CB_ADD];
    assign op_sub              = q.ctrl[alp_pkg::CB_SUB];
    assign op_inc              = q.ctrl[alp_pkg::CB_INC];
    assign op_dec              = q.ctrl[alp_pkg::CB_DEC];
    assign half_arith          = q.ctrl[alp_pkg::CB_HALF];
    assign width_sel           = q.ctrl[alp_pkg::CB_WID +: 2];
    assign thread_select_code  = q.ctrl[alp_pkg::CB_TSEL +: 3];
    assign current_instr_field = q.ctrl[alp_pkg::CB_RFLD +: 4];

    // Operand sources for the adder, and the true main-bus word that only feeds the unload outputs.
    logic [31:0] const_out;
    logic [31:0] main_operand_true;
    logic [31:0] per_thread_register_file;
    logic        halfword_arith_flag;

    // Constant or complement selection, decrement and increment taking priority.
    always_comb begin
        if (op_dec) begin
            const_out = alp_pkg::CONST_DEC;
        end else if (op_inc) begin
            const_out = alp_pkg::CONST_INC;
        end else if (op_sub) begin
            const_out = ~q.aligned;
        end else begin
            // true for add, and when no operation is selected
            const_out = q.aligned;
        end
    end

    assign main_operand_true        = ~q.bus_n;
    assign per_thread_register_file = q.rf_word;
    assign halfword_arith_flag      = half_arith & (op_add | op_sub);

    // Slice outputs, byte 0 being the most significant byte.
    logic [31:0] sl_gen;
    logic [31:0] sl_prop;
    logic [31:0] sl_log;
    logic [3:0]  sl_nib_p;
    logic [3:0]  sl_nib_g;
    logic [3:0]  sl_byte_p;
    logic [3:0]  sl_byte_g;

    for (genvar g = 0; g < 4; g++) begin : g_slice
        alp_byte_slice u_slice (
            .a         (const_out[31-8*g -: 8]),
            .b         (per_thread_register_file[31-8*g -: 8]),
            .force_top (halfword_arith_flag && (g == 2)),
            .sub_mode  (op_sub),
            .or_en     (q.ctrl[alp_pkg::CB_OR]),
            .xor_en    (q.ctrl[alp_pkg::CB_XOR]),
            .eqv_en    (q.ctrl[alp_pkg::CB_EQV]),
            .and_en    (q.ctrl[alp_pkg::CB_AND]),
            .gen       (sl_gen[31-8*g -: 8]),
            .prop      (sl_prop[31-8*g -: 8]),
            .log_out   (sl_log[31-8*g -: 8]),
            .nib_p     (sl_nib_p[3-g]),
            .nib_g     (sl_nib_g[3-g]),
            .byte_p    (sl_byte_p[3-g]),
            .byte_g    (sl_byte_g[3-g])
        );
    end

    // Width mask for the logical result; narrow operations use the right end of the word.
    logic [31:0] width_mask;

    always_comb begin
        unique case (width_sel)
            alp_pkg::ALP_WID_BYTE: width_mask = 32'h0000_00FF;
            alp_pkg::ALP_WID_HALF: width_mask = 32'h0000_FFFF;
            alp_pkg::ALP_WID_WORD: width_mask = 32'hFFFF_FFFF;
            default:               width_mask = 32'hFFFF_FFFF;
        endcase
    end

    // Next state: bus slave handshakes, register writes and result capture.
    always_comb begin
        d = q;

        // Completed responses retire when the master accepts them.
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end

        // Write address and data are taken independently.
        if (s_axi_awvalid && q.aw_rdy) begin
            d.aw_got  = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && q.w_rdy) begin
            d.w_got  = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end

        // Both halves present: perform the write and raise the response.
        if (q.aw_got && q.w_got && !q.bvalid) begin
            d.aw_got = 1'b0;
            d.w_got  = 1'b0;
            d.bvalid = 1'b1;
            d.bresp  = addr_mapped(q.aw_addr) ? alp_pkg::RESP_OKAY : alp_pkg::RESP_SLVERR;
            case (q.aw_addr)
                alp_pkg::OFF_CTRL:    d.ctrl    = merge_strb(q.ctrl, q.w_data, q.w_strb);
                alp_pkg::OFF_ALIGNED: d.aligned = merge_strb(q.aligned, q.w_data, q.w_strb);
                alp_pkg::OFF_MAINBUS: d.bus_n   = merge_strb(q.bus_n, q.w_data, q.w_strb);
                alp_pkg::OFF_RFWORD:  d.rf_word = merge_strb(q.rf_word, q.w_data, q.w_strb);
                default:              d.ctrl    = q.ctrl;
            endcase
        end

        // Reads answer one cycle after the address is taken.
        if (s_axi_arvalid && q.ar_rdy) begin
            d.rvalid = 1'b1;
            d.rdata  = read_mux(q, s_axi_araddr);
            d.rresp  = addr_mapped(s_axi_araddr) ? alp_pkg::RESP_OKAY : alp_pkg::RESP_SLVERR;
        end

        d.aw_rdy = !d.aw_got && !d.bvalid;
        d.w_rdy  = !d.w_got && !d.bvalid;
        d.ar_rdy = !d.rvalid;

        d.const_w = const_out;
        d.gen     = sl_gen;
        d.prop    = sl_prop;
        {d.gen_n, d.prop_n} = ~{sl_gen, sl_prop};
        d.logic_w = sl_log & width_mask;
        d.nib_p   = sl_nib_p;
        d.nib_g   = sl_nib_g;
        d.byte_p  = sl_byte_p;
        d.byte_g  = sl_byte_g;
        d.onehot  = 8'h01 << thread_select_code;
        d.onehot_n = ~(8'h01 << thread_select_code);
        d.rfield  = current_instr_field;
        d.rfield_n = ~current_instr_field;
        d.unload  = main_operand_true;
        d.unload_n = ~main_operand_true;
        d.rail    = per_thread_register_file;
        d.rail_n  = ~per_thread_register_file;
    end

    // State register with asynchronous active-low reset.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q         <= '0;
            q.ctrl    <= alp_pkg::CTRL_RST;
            q.aw_rdy  <= 1'b1;
            q.w_rdy   <= 1'b1;
            q.ar_rdy  <= 1'b1;
            q.unload  <= 32'hFFFF_FFFF;
            q.onehot  <= 8'h01;
            {q.gen_n, q.prop_n, q.rail_n} <= '1;
            {q.onehot_n, q.rfield_n} <= {8'hFE, 4'hF};
        end else begin
            q <= d;
        end
    end

    // Bus outputs straight from the state register.
    assign s_axi_awready = q.aw_rdy;
    assign s_axi_wready  = q.w_rdy;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = q.ar_rdy;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;

    // Result outputs, double-rail except the logic and group-carry ones; every rail has its own flop, so no output follows logic.
    // generate with inverse
    assign adder_gen            = q.gen;
    assign adder_gen_n          = q.gen_n;
    assign adder_prop           = q.prop;
    assign adder_prop_n         = q.prop_n;
    assign logic_result         = q.logic_w;
    assign low_nibble_propagate = q.nib_p;
    assign low_nibble_generate  = q.nib_g;
    assign byte_group_propagate = q.byte_p;
    assign byte_group_generate  = q.byte_g;
    assign thread_onehot        = q.onehot;
    assign thread_onehot_n      = q.onehot_n;
    assign reg_field            = q.rfield;
    assign reg_field_n          = q.rfield_n;
    assign unload_word          = q.unload;
    assign unload_word_n        = q.unload_n;
    assign rail_word            = q.rail;
    assign rail_word_n          = q.rail_n;

endmodule // alp_operand_prep

`default_nettype wire

// ### inc/alp_pkg.sv
`default_nettype none

package alp_pkg;

    // Register byte addresses, one aligned word each.
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_ALIGNED = 8'h04;
    localparam logic [7:0] OFF_MAINBUS = 8'h08;
    localparam logic [7:0] OFF_RFWORD  = 8'h0C;
    localparam logic [7:0] OFF_CONST   = 8'h10;
    localparam logic [7:0] OFF_GEN     = 8'h14;
    localparam logic [7:0] OFF_PROP    = 8'h18;
    localparam logic [7:0] OFF_LOGIC   = 8'h1C;
    localparam logic [7:0] OFF_GROUP   = 8'h20;
    localparam logic [7:0] OFF_SELECT  = 8'h24;
    localparam logic [7:0] OFF_UNLOAD  = 8'h28;
    localparam logic [7:0] OFF_RAIL    = 8'h2C;

    // Control register field positions.
    localparam int unsigned CB_ADD   = 0;
    localparam int unsigned CB_SUB   = 1;
    localparam int unsigned CB_INC   = 2;
    localparam int unsigned CB_DEC   = 3;
    localparam int unsigned CB_HALF  = 4;
    localparam int unsigned CB_WID   = 5;
    localparam int unsigned CB_OR    = 7;
    localparam int unsigned CB_XOR   = 8;
    localparam int unsigned CB_EQV   = 9;
    localparam int unsigned CB_AND   = 10;
    localparam int unsigned CB_TSEL  = 12;
    localparam int unsigned CB_RFLD  = 16;

    // Operation width codes in the control register.
    typedef enum logic [1:0] {
        ALP_WID_BYTE = 2'b00,
        ALP_WID_HALF = 2'b01,
        ALP_WID_WORD = 2'b10
    } alp_width_t;

    // Reset values and constants.
    localparam logic [31:0] CTRL_RST  = 32'h0000_0040;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] CONST_DEC = 32'hFFFF_FFFF;
    localparam logic [31:0] CONST_INC = 32'h0001_0001;
    localparam logic [1:0]  RESP_OKAY   = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;

    // Whole state of the top module.
    typedef struct packed {
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        aw_rdy;
        logic        w_rdy;
        logic        ar_rdy;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [31:0] ctrl;
        logic [31:0] aligned;
        logic [31:0] bus_n;
        logic [31:0] rf_word;
        logic [31:0] const_w;
        logic [31:0] gen;
        logic [31:0] gen_n;
        logic [31:0] prop;
        logic [31:0] prop_n;
        logic [31:0] logic_w;
        logic [3:0]  nib_p;
        logic [3:0]  nib_g;
        logic [3:0]  byte_p;
        logic [3:0]  byte_g;
        logic [7:0]  onehot;
        logic [7:0]  onehot_n;
        logic [3:0]  rfield;
        logic [3:0]  rfield_n;
        logic [31:0] unload;
        logic [31:0] unload_n;
        logic [31:0] rail;
        logic [31:0] rail_n;
    } alp_state_t;

endpackage

`default_nettype wire

// ### design/alp_byte_slice.sv
`default_nettype none

// One byte of adder levels one and two; index 0 is the byte's most significant bit.
module alp_byte_slice (
    input  wire logic [0:7] a,
    input  wire logic [0:7] b,
    input  wire logic       force_top,
    input  wire logic       sub_mode,
    input  wire logic       or_en,
    input  wire logic       xor_en,
    input  wire logic       eqv_en,
    input  wire logic       and_en,
    output logic      [0:7] gen,
    output logic      [0:7] prop,
    output logic      [0:7] log_out,
    output logic            nib_p,
    output logic            nib_g,
    output logic            byte_p,
    output logic            byte_g
);

    // Per-bit generate, propagate and logical result.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            gen[i] = a[i] & b[i];
            prop[i] = a[i] ^ b[i];
        end
        if (force_top) begin
            prop[0] = 1'b0;
            gen[0]  = sub_mode;
        end
        for (int i = 0; i < 8; i++) begin
            log_out[i] = (or_en & (a[i] | b[i])) | (xor_en & prop[i])
                       | (eqv_en & ~prop[i]) | (and_en & gen[i]);
        end
    end

    // Group carries; a carry moves toward index 0, passing each more significant propagate.
    always_comb begin
        nib_p = &prop[4:7];
        nib_g = gen[4] | (gen[5] & prop[4]) | (gen[6] & prop[4] & prop[5])
              | (gen[7] & prop[4] & prop[5] & prop[6]);
        byte_p = &prop;
        byte_g = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            byte_g = gen[i] | (prop[i] & byte_g);
        end
    end

endmodule // alp_byte_slice

`default_nettype wire

// ### verif/alp_monitor.sv
`default_nettype none

// Watches the result ports for double-rail, group-carry and bus-answer consistency.
module alp_monitor (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] adder_gen,
    input wire logic [31:0] adder_gen_n,
    input wire logic [31:0] adder_prop,
    input wire logic [31:0] adder_prop_n,
    input wire logic [3:0]  low_nibble_propagate,
    input wire logic [3:0]  low_nibble_generate,
    input wire logic [3:0]  byte_group_propagate,
    input wire logic [3:0]  byte_group_generate,
    input wire logic [7:0]  thread_onehot,
    input wire logic [7:0]  thread_onehot_n,
    input wire logic [3:0]  reg_field,
    input wire logic [3:0]  reg_field_n,
    input wire logic [31:0] unload_word,
    input wire logic [31:0] unload_word_n,
    input wire logic [31:0] rail_word,
    input wire logic [31:0] rail_word_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] nib_p_e, nib_g_e, byte_p_e, byte_g_e;
    logic       gg;

    // Rebuilds group carries from the bit signals; bit 0 of a byte is its most significant.
    always_comb begin
        nib_g_e = 4'h0;
        for (int j = 0; j < 4; j++) begin
            gg = 1'h0;
            for (int i = 7; i >= 0; i--) begin
                gg = adder_gen[8*j+7-i] | (adder_prop[8*j+7-i] & gg);
                if (i == 4) nib_g_e[j] = gg;
            end
            byte_g_e[j] = gg;
            nib_p_e[j] = &adder_prop[8*j +: 4];
            byte_p_e[j] = &adder_prop[8*j +: 8];
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // Bus transfers taken and their answers.
    sequence write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence write_answer;
        ##2 s_axi_bvalid;
    endsequence
    sequence read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    write_resp_a: assert property (write_taken |-> write_answer)
        else $error("write response not two edges after the request");
    write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write response not withdrawn");
    read_resp_a: assert property (read_taken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read data late");
    read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read data not withdrawn");
    gen_rail_a: assert property (adder_gen_n == ~adder_gen && (adder_gen & adder_prop) == 0)
        else $error("generate rails inconsistent");
    prop_rail_a: assert property (adder_prop_n == ~adder_prop) else $error("prop rails");
    thread_code_a: assert property ($onehot(thread_onehot) && thread_onehot_n == ~thread_onehot)
        else $error("thread select not one-hot double rail");
    reg_field_a: assert property (reg_field_n == ~reg_field) else $error("field rails");
    unload_rail_a: assert property (unload_word_n == ~unload_word)
        else $error("unload word rails inconsistent");
    operand_rail_a: assert property (rail_word_n == ~rail_word) else $error("rf rails");
    nibble_group_a: assert property ({low_nibble_propagate, low_nibble_generate} == {nib_p_e, nib_g_e})
        else $error("low nibble group carry wrong");
    byte_group_a: assert property ({byte_group_propagate, byte_group_generate} == {byte_p_e, byte_g_e})
        else $error("byte group carry wrong");
endmodule // alp_monitor

bind alp_operand_prep alp_monitor u_monitor (.*);

`default_nettype wire

// ### verif/alp_axi_master.sv
`default_nettype none

// Register-bus master standing in for the control logic that programs the block.
module alp_axi_master (
    input wire logic         clk_sys,
    output logic      [7:0]  s_axi_awaddr,
    output logic             s_axi_awvalid,
    input wire logic         s_axi_awready,
    output logic      [31:0] s_axi_wdata,
    output logic      [3:0]  s_axi_wstrb,
    output logic             s_axi_wvalid,
    input wire logic         s_axi_wready,
    input wire logic  [1:0]  s_axi_bresp,
    input wire logic         s_axi_bvalid,
    output logic             s_axi_bready,
    output logic      [7:0]  s_axi_araddr,
    output logic             s_axi_arvalid,
    input wire logic         s_axi_arready,
    input wire logic  [31:0] s_axi_rdata,
    input wire logic  [1:0]  s_axi_rresp,
    input wire logic         s_axi_rvalid,
    output logic             s_axi_rready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero.
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
             s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;

    // Offers address and data together; a released payload shows its inverse, never stale data.
    task automatic write(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] st,
                         output logic [1:0] resp);
        @(posedge clk_sys);
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'h0;
                s_axi_awaddr <= ~ad;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'h0;
                s_axi_wdata <= ~d;
                s_axi_wstrb <= ~st;
            end
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask

    // Read transfer; rready stays high until the data is seen.
    task automatic read(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] resp);
        @(posedge clk_sys);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'h0;
                s_axi_araddr <= ~ad;
            end
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask
endmodule // alp_axi_master

`default_nettype wire

// ### verif/tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_b;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, thread_onehot, thread_onehot_n;
    logic [31:0] s_axi_wdata, s_axi_rdata, adder_gen, adder_gen_n, adder_prop, adder_prop_n;
    logic [31:0] logic_result, unload_word, unload_word_n, rail_word, rail_word_n, rd;
    logic [3:0]  s_axi_wstrb, low_nibble_propagate, low_nibble_generate, byte_group_propagate;
    logic [3:0]  byte_group_generate, reg_field, reg_field_n;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          errors = 0, n_checks = 0;
    integer      seed = 32'h9fb2_3dd8;
    logic [31:0] m_reg [0:11];
    logic [31:0] ops [15] = '{32'h0000_0041, 32'h0000_0042, 32'h0000_0044, 32'h0000_0048,
        32'h0000_0040, 32'h0000_004E, 32'h0000_0046, 32'h0000_0051, 32'h0000_0012, 32'h0000_0010,
        32'h0000_00C0, 32'h0000_0120, 32'h0000_0200, 32'h0000_0460, 32'h0000_0792};

    alp_operand_prep uut (.*);
    alp_axi_master u_bus (.*);

    // Free-running system clock.
    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Recomputes every result register from the writable ones.
    task automatic model();
        logic [31:0] c, a, b, g, p, lg;
        logic [3:0]  np, ng, bp, bg;
        logic        gg;
        c = m_reg[0];
        b = m_reg[3];
        a = c[3] ? 32'hFFFF_FFFF : c[2] ? 32'h0001_0001 : c[1] ? ~m_reg[1] : m_reg[1];
        g = a & b;
        p = a ^ b;
        if (c[4] && (c[0] || c[1])) begin
            p[15] = 1'h0;
            g[15] = c[1];
        end
        lg = ({32{c[7]}} & (a | b)) | ({32{c[8]}} & p) | ({32{c[9]}} & ~p) | ({32{c[10]}} & g);
        lg = (c[6:5] == 2'h0) ? lg & 32'h0000_00FF : (c[6:5] == 2'h1) ? lg & 32'h0000_FFFF : lg;
        for (int j = 0; j < 4; j++) begin
            gg = 1'h0;
            for (int i = 7; i >= 0; i--) begin
                gg = g[8*j+7-i] | (p[8*j+7-i] & gg);
                if (i == 4) ng[j] = gg;
            end
            bg[j] = gg;
            np[j] = &p[8*j +: 4];
            bp[j] = &p[8*j +: 8];
        end
        m_reg[4:11] = '{a, g, p, lg, {16'h0000, bg, bp, ng, np},
                        {20'h0_0000, c[19:16], 8'h01 << c[14:12]}, ~m_reg[2], b};
    endtask

    // Compares one word result.
    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Compares one bus response code.
    task automatic chk_resp(string what, logic [1:0] exp, logic [1:0] got);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bus write, response check and model update with strobe merging.
    task automatic wr(logic [7:0] ad, logic [31:0] d, logic [3:0] st);
        u_bus.write(ad, d, st, rs);
        chk_resp("write resp", (ad > 8'h2C || ad[1:0] != 2'h0) ? 2'h2 : 2'h0, rs);
        if (ad < 8'h10 && ad[1:0] == 2'h0) begin
            for (int k = 0; k < 4; k++) if (st[k]) m_reg[ad[3:2]][8*k +: 8] = d[8*k +: 8];
            model();
        end
    endtask

    // Reads every register and compares the result ports.
    task automatic check_all();
        for (int r = 0; r < 12; r++) begin
            u_bus.read(8'(4 * r), rd, rs);
            chk_resp("read resp", 2'h0, rs);
            chk_word($sformatf("register %0d", r), m_reg[r], rd);
        end
        chk_word("gen port", m_reg[5], adder_gen);
        chk_word("prop port", m_reg[6], adder_prop);
        chk_word("logic port", m_reg[7], logic_result);
        chk_word("group ports", m_reg[8], {16'h0000, byte_group_generate, byte_group_propagate,
                 low_nibble_generate, low_nibble_propagate});
        chk_word("select ports", m_reg[9], {20'h0_0000, reg_field, thread_onehot});
        chk_word("unload port", m_reg[10], unload_word);
        chk_word("rail port", m_reg[11], rail_word);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        print_verdict();
    end

    // Main sequence of tests.
    initial begin
        rst_b = 1'h0;
        m_reg = '{0: alp_pkg::CTRL_RST, default: 32'h0000_0000};
        model();
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'h1;
        check_all();
        $display("test reset done");
        foreach (ops[i]) begin
            wr(8'h04, $random(seed), 4'hF);
            wr(8'h0C, $random(seed), 4'hF);
            wr(8'h00, ops[i], 4'hF);
            check_all();
        end
        $display("test operations done");
        for (int t = 0; t < 8; t++) begin
            wr(8'h00, 32'((t << 12) | ((15 - t) << 16)) | 32'h0000_0041, 4'hF);
            check_all();
        end
        $display("test thread codes done");
        repeat (24) begin
            wr(8'h08, $random(seed), 4'hF);
            wr(8'h0C, $random(seed), 4'hF);
            wr(8'h04, $random(seed), 4'hF);
            wr(8'h00, $random(seed) & 32'h000F_77FF, 4'hF);
            check_all();
        end
        $display("test random operands done");
        wr(8'h10, $random(seed), 4'hF);
        wr(8'h30, $random(seed), 4'hF);
        wr(8'h06, $random(seed), 4'hF);
        wr(8'h04, $random(seed), 4'h5);
        wr(8'h08, $random(seed), 4'h8);
        u_bus.read(8'h30, rd, rs);
        chk_resp("unmapped read", 2'h2, rs);
        chk_word("unmapped data", 32'h0000_0000, rd);
        u_bus.read(8'h05, rd, rs);
        chk_resp("unaligned read", 2'h2, rs);
        check_all();
        $display("test bus edge cases done");
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
